// [verilog/adcr_pkg.sv]
// shared constants and carrier types of the converter control block
package adcr_pkg;
  // result width of the converter core
  localparam int ADCR_RES_W = 10;
  // apb byte offsets of the register words
  localparam logic [7:0] ADCR_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ADCR_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ADCR_OFF_RESH = 8'h08;
  localparam logic [7:0] ADCR_OFF_RESL = 8'h0C;
  localparam logic [7:0] ADCR_OFF_STAT = 8'h10;
  // control word 0 field positions
  localparam int ADCR_C0_EN_BIT = 0;
  localparam int ADCR_C0_GO_BIT = 1;
  localparam int ADCR_C0_CHAN_LSB = 2;
  localparam int ADCR_C0_CHAN_MSB = 6;
  // control word 1 field positions
  localparam int ADCR_C1_REF_LSB = 0;
  localparam int ADCR_C1_REF_MSB = 1;
  localparam int ADCR_C1_CS_LSB = 4;
  localparam int ADCR_C1_CS_MSB = 6;
  localparam int ADCR_C1_JUST_BIT = 7;
  // status word field position
  localparam int ADCR_ST_DONE_BIT = 0;
  // values after reset
  localparam logic [7:0] ADCR_CTRL_RST = 8'h00;
  // channel codes bounding the connected inputs
  localparam logic [4:0] ADCR_CHAN_LAST_PIN = 5'h03;
  localparam logic [4:0] ADCR_CHAN_TEMP = 5'h1D;
  // conversion clock select codes; x11 picks the rc oscillator
  localparam logic [2:0] ADCR_CS_DIV2 = 3'h0;
  localparam logic [2:0] ADCR_CS_DIV8 = 3'h1;
  localparam logic [2:0] ADCR_CS_DIV32 = 3'h2;
  localparam logic [2:0] ADCR_CS_DIV4 = 3'h4;
  localparam logic [2:0] ADCR_CS_DIV16 = 3'h5;
  localparam logic [2:0] ADCR_CS_DIV64 = 3'h6;
  // divider lengths in system clock cycles
  localparam logic [6:0] ADCR_LEN_DIV2 = 7'h02;
  localparam logic [6:0] ADCR_LEN_DIV4 = 7'h04;
  localparam logic [6:0] ADCR_LEN_DIV8 = 7'h08;
  localparam logic [6:0] ADCR_LEN_DIV16 = 7'h10;
  localparam logic [6:0] ADCR_LEN_DIV32 = 7'h20;
  localparam logic [6:0] ADCR_LEN_DIV64 = 7'h40;
  // conversion sequencer states
  typedef enum logic {ADCR_IDLE, ADCR_CONVERT} adcr_state_e;
  // request towards the analog converter core
  typedef struct packed {
    logic enable;
    logic connect;
    logic [4:0] channel;
    logic [1:0] pos_ref;
    logic start;
    logic abort;
  } adcr_core_req_s;
  // answer from the analog converter core
  typedef struct packed {
    logic done;
    logic [ADCR_RES_W-1:0] result;
    logic [3:0] bits_done;
  } adcr_core_rsp_s;
endpackage

// [verilog/adcr_tad_div.sv]
// conversion clock tick generator
module adcr_tad_div
  import adcr_pkg::*;
(
  // clock, reset and freeze
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // selection
  input wire logic run,
  input wire logic [2:0] conv_clock_sel,
  input wire logic rc_tick,
  // one tick per conversion clock period
  output logic tad_tick_r
);
  logic [6:0] cnt_r; // cycles since the last tick
  logic [6:0] div_len; // period of the chosen divider
  logic rc_sel; // x11 selects the rc oscillator

  assign rc_sel = (conv_clock_sel[1:0] == 2'h3);

  // decode the divider length
  always_comb begin
    unique case (conv_clock_sel)
      ADCR_CS_DIV2: div_len = ADCR_LEN_DIV2;
      ADCR_CS_DIV8: div_len = ADCR_LEN_DIV8;
      ADCR_CS_DIV32: div_len = ADCR_LEN_DIV32;
      ADCR_CS_DIV4: div_len = ADCR_LEN_DIV4;
      ADCR_CS_DIV16: div_len = ADCR_LEN_DIV16;
      ADCR_CS_DIV64: div_len = ADCR_LEN_DIV64;
      default: div_len = ADCR_LEN_DIV2; // rc codes, length unused
    endcase
  end

  // free count only while converting, so every conversion on a divider code starts aligned; rc codes pass rc_tick through
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r <= 7'h00;
      tad_tick_r <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_r <= 7'h00;
        tad_tick_r <= 1'b0;
      end else if (rc_sel) begin
        cnt_r <= 7'h00;
        tad_tick_r <= rc_tick;
      end else if (cnt_r == div_len - 7'h01) begin
        cnt_r <= 7'h00;
        tad_tick_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 7'h01;
        tad_tick_r <= 1'b0;
      end
    end
  end

  AST_TAD_DIV4_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tad_tick_r && run && clk_en && conv_clock_sel == ADCR_CS_DIV4)
    ##1 (run && clk_en && conv_clock_sel == ADCR_CS_DIV4)[*3] |=> tad_tick_r)
    else $error("divide by four tick period wrong");
endmodule // adcr_tad_div

// [verilog/adcr_fill.sv]
// fills unconverted low bits of a partial result
module adcr_fill
  import adcr_pkg::*;
#(
  parameter int RES_W = ADCR_RES_W
)
(
  // partial value and number of converted top bits
  input wire logic [RES_W-1:0] raw,
  input wire logic [3:0] bits_done,
  // value with the gaps filled
  output logic [RES_W-1:0] filled
);
  logic [3:0] low_idx; // index of the last converted bit
  logic all_done; // no gap to fill
  logic last_bit; // value copied into the gap

  assign all_done = (bits_done >= 4'(RES_W));
  assign low_idx = all_done ? 4'h0 : 4'(RES_W) - bits_done;
  // nothing converted yet gives zero rather than an undefined bit
  assign last_bit = (bits_done == 4'h0) ? 1'b0 : raw[low_idx];

  // each bit keeps its value or copies the last converted one
  for (genvar i = 0; i < RES_W; i++) begin : g_bit
    assign filled[i] = (all_done || 4'(i) >= low_idx) ? raw[i] : last_bit;
  end
endmodule // adcr_fill

// [verilog/adcr_ctrl.sv]
// converter control, result registers and apb slave
//
// Design decisions made here: register access over APB and the register offsets.
module adcr_ctrl
  import adcr_pkg::*;
(
  // clock, reset and freeze
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // compare unit trigger
  input wire logic special_event_trig,
  output logic trig_timer_clear_r,
  // analog converter core
  output adcr_core_req_s core_req_r,
  input wire adcr_core_rsp_s core_rsp,
  input wire logic rc_tick,
  output logic tad_tick_r,
  // completion flag towards the interrupt controller
  output logic conv_done_flag_r
);
  // control word 0
  logic converter_enable_r;
  logic go_r; // start and busy bit
  logic [4:0] input_channel_sel_r;
  // control word 1
  logic result_justify_sel_r;
  logic [2:0] conv_clock_sel_r;
  logic [1:0] pos_ref_sel_r;
  // result words, deliberately without reset
  logic [7:0] result_high_r;
  logic [7:0] result_low_r;
  // sequencer
  adcr_state_e state_r;
  logic [ADCR_RES_W-1:0] partial_filled; // aborted value with gaps filled
  logic [ADCR_RES_W-1:0] load_val; // value to format into results
  logic load_en; // results take a new value this cycle
  logic conv_done; // core finished while converting
  logic conv_abort; // software cleared the busy bit
  // bus decode
  logic apb_acc; // first access cycle, answer goes out
  logic apb_wr; // write takes effect this edge
  logic hit_c0;
  logic hit_c1;
  logic hit_rh;
  logic hit_rl;
  logic hit_st;
  logic hit_any;
  logic [7:0] rd_val; // read word before the flop

  // bus phases: answer one cycle into the access phase
  assign apb_acc = psel && penable && !pready_r;
  assign apb_wr = psel && penable && pready_r && pwrite && hit_any;
  assign hit_c0 = (paddr == ADCR_OFF_CTRL0);
  assign hit_c1 = (paddr == ADCR_OFF_CTRL1);
  assign hit_rh = (paddr == ADCR_OFF_RESH);
  assign hit_rl = (paddr == ADCR_OFF_RESL);
  assign hit_st = (paddr == ADCR_OFF_STAT);
  assign hit_any = hit_c0 || hit_c1 || hit_rh || hit_rl || hit_st;

  // sequencer events
  assign conv_done = (state_r == ADCR_CONVERT) && converter_enable_r && core_rsp.done;
  assign conv_abort = (state_r == ADCR_CONVERT) && converter_enable_r && !core_rsp.done
    && !go_r;
  assign load_en = conv_done || conv_abort;
  assign load_val = conv_done ? core_rsp.result : partial_filled;

  // gap filler for aborted conversions
  adcr_fill #(
    .RES_W(ADCR_RES_W)
  ) adcr_fill_inst (
    .raw(core_rsp.result),
    .bits_done(core_rsp.bits_done),
    .filled(partial_filled)
  );

  // conversion clock ticks only while converting
  adcr_tad_div adcr_tad_div_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .run(state_r == ADCR_CONVERT),
    .conv_clock_sel(conv_clock_sel_r),
    .rc_tick(rc_tick),
    .tad_tick_r(tad_tick_r)
  );

  // apb handshake and read data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (apb_acc) begin
        pready_r <= 1'b1;
        pslverr_r <= !hit_any; // unmapped answers with an error
        prdata_r <= {24'h00_0000, rd_val};
      end else begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  // read multiplexer
  always_comb begin
    rd_val = 8'h00; // unmapped reads zero
    if (hit_c0) begin
      rd_val = {1'b0, input_channel_sel_r, go_r, converter_enable_r};
    end else if (hit_c1) begin
      rd_val = {result_justify_sel_r, conv_clock_sel_r, 2'h0, pos_ref_sel_r};
    end else if (hit_rh) begin
      rd_val = result_high_r;
    end else if (hit_rl) begin
      rd_val = result_low_r;
    end else if (hit_st) begin
      rd_val = {7'h00, conv_done_flag_r};
    end
  end

  // configuration fields of both control words
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      converter_enable_r <= ADCR_CTRL_RST[ADCR_C0_EN_BIT];
      input_channel_sel_r <= ADCR_CTRL_RST[ADCR_C0_CHAN_MSB:ADCR_C0_CHAN_LSB];
      result_justify_sel_r <= ADCR_CTRL_RST[ADCR_C1_JUST_BIT];
      conv_clock_sel_r <= ADCR_CTRL_RST[ADCR_C1_CS_MSB:ADCR_C1_CS_LSB];
      pos_ref_sel_r <= ADCR_CTRL_RST[ADCR_C1_REF_MSB:ADCR_C1_REF_LSB];
    end else if (clk_en && apb_wr) begin
      if (hit_c0) begin
        converter_enable_r <= pwdata[ADCR_C0_EN_BIT];
        input_channel_sel_r <= pwdata[ADCR_C0_CHAN_MSB:ADCR_C0_CHAN_LSB];
      end
      if (hit_c1) begin
        result_justify_sel_r <= pwdata[ADCR_C1_JUST_BIT];
        conv_clock_sel_r <= pwdata[ADCR_C1_CS_MSB:ADCR_C1_CS_LSB];
        pos_ref_sel_r <= pwdata[ADCR_C1_REF_MSB:ADCR_C1_REF_LSB];
      end
    end
  end

  // start and busy bit; the trigger beats a clear in the same cycle, except a control 0 write that clears enable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      go_r <= ADCR_CTRL_RST[ADCR_C0_GO_BIT];
    end else if (clk_en) begin
      if (apb_wr && hit_c0 && !pwdata[ADCR_C0_EN_BIT]) begin
        go_r <= 1'b0; // disabling drops any conversion
      end else if (special_event_trig && converter_enable_r) begin
        go_r <= 1'b1;
      end else if (apb_wr && hit_c0) begin
        go_r <= pwdata[ADCR_C0_GO_BIT];
      end else if (conv_done) begin
        go_r <= 1'b0;
      end
    end
  end

  // trigger timer is cleared on the cycle after the pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trig_timer_clear_r <= 1'b0;
    end else if (clk_en) begin
      trig_timer_clear_r <= special_event_trig;
    end
  end

  // sequencer; a start while disabled is not accepted
  // dropping enable mid-conversion returns to idle without a load
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ADCR_IDLE;
    end else if (clk_en) begin
      unique case (state_r)
        ADCR_IDLE: begin
          if (go_r && converter_enable_r) begin
            state_r <= ADCR_CONVERT;
          end
        end
        ADCR_CONVERT: begin
          if (!converter_enable_r || load_en) begin
            state_r <= ADCR_IDLE;
          end
        end
      endcase
    end
  end

  // requests to the core, registered so the outputs come from flops
  // start and abort last one cycle; the core must sample every edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      core_req_r <= '0;
    end else if (clk_en) begin
      core_req_r.enable <= converter_enable_r;
      // reserved codes leave the sample switch open
      core_req_r.connect <= (input_channel_sel_r <= ADCR_CHAN_LAST_PIN)
        || (input_channel_sel_r >= ADCR_CHAN_TEMP);
      core_req_r.channel <= input_channel_sel_r;
      core_req_r.pos_ref <= pos_ref_sel_r;
      core_req_r.start <= (state_r == ADCR_IDLE) && go_r && converter_enable_r;
      core_req_r.abort <= conv_abort
        || ((state_r == ADCR_CONVERT) && !converter_enable_r);
    end
  end

  // result words: no reset, a hardware load beats a software write
  // a software write in a load cycle is lost; the load carries fresher data
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (load_en && result_justify_sel_r) begin
        result_high_r <= {6'h00, load_val[9:8]};
        result_low_r <= load_val[7:0];
      end else if (load_en) begin
        result_high_r <= load_val[9:2];
        result_low_r <= {load_val[1:0], 6'h00};
      end else if (apb_wr) begin
        if (hit_rh) begin
          result_high_r <= pwdata[7:0];
        end
        if (hit_rl) begin
          result_low_r <= pwdata[7:0];
        end
      end
    end
  end

  // completion flag: write one clears, a completion in that cycle wins
  // losing a completion would hang an interrupt-driven driver, so set wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conv_done_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (conv_done) begin
        conv_done_flag_r <= 1'b1;
      end else if (apb_wr && hit_st && pwdata[ADCR_ST_DONE_BIT]) begin
        conv_done_flag_r <= 1'b0;
      end
    end
  end

  AST_TRIG_SETS_GO: assert property (@(posedge core_clk) disable iff (sys_rst)
    (special_event_trig && converter_enable_r && clk_en && !(apb_wr && hit_c0))
    |=> go_r ##0 trig_timer_clear_r)
    else $error("trigger did not set start bit and clear timer");

  AST_TRIG_TIMER_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && !special_event_trig) |=> !trig_timer_clear_r)
    else $error("timer clear without trigger");

  AST_START_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (apb_wr && hit_c0 && pwdata[1:0] == 2'h3 && state_r == ADCR_IDLE && clk_en)
    ##1 clk_en |=> core_req_r.start ##0 state_r == ADCR_CONVERT)
    else $error("start write did not launch a conversion");

  AST_DONE_EFFECTS: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_done && clk_en && !special_event_trig && !(apb_wr && hit_c0))
    |=> !go_r && conv_done_flag_r && state_r == ADCR_IDLE)
    else $error("completion effects missing");

  AST_RIGHT_FORMAT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_done && result_justify_sel_r && clk_en)
    |=> result_high_r == {6'h00, $past(core_rsp.result[9:8])}
      && result_low_r == $past(core_rsp.result[7:0]))
    else $error("right justified result wrong");

  AST_LEFT_FORMAT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_done && !result_justify_sel_r && clk_en)
    |=> result_high_r == $past(core_rsp.result[9:2])
      && result_low_r == {$past(core_rsp.result[1:0]), 6'h00})
    else $error("left justified result wrong");

  AST_ABORT_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_abort && clk_en && !(apb_wr && hit_st))
    |=> core_req_r.abort && state_r == ADCR_IDLE
      && conv_done_flag_r == $past(conv_done_flag_r))
    else $error("abort not handled");

  AST_CTRL0_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
    (psel && penable && pready_r && hit_c0) |-> prdata_r[31:7] == 25'h000_0000)
    else $error("control 0 upper bits not zero");

  AST_CTRL1_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
    (psel && penable && pready_r && hit_c1)
    |-> prdata_r[3:2] == 2'h0 && prdata_r[31:8] == 24'h00_0000)
    else $error("control 1 reserved bits not zero");

  AST_ENABLE_FOLLOWS: assert property (@(posedge core_clk) disable iff (sys_rst)
    (apb_wr && hit_c0 && clk_en) ##1 clk_en |=> core_req_r.enable == $past(pwdata[0], 2))
    else $error("core enable does not follow control write");

  // the checks below cover corners the bench reaches rarely
  AST_ABORT_TOP_BITS: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_abort && result_justify_sel_r && clk_en && core_rsp.bits_done >= 4'h2)
    |=> result_high_r == {6'h00, $past(core_rsp.result[9:8])})
    else $error("aborted result lost its converted top bits");

  AST_RESERVED_OPEN: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && input_channel_sel_r > ADCR_CHAN_LAST_PIN
      && input_channel_sel_r < ADCR_CHAN_TEMP)
    |=> !core_req_r.connect)
    else $error("reserved channel code closed the sample switch");

  AST_DISABLED_QUIET: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && !converter_enable_r) |=> !core_req_r.enable && !core_req_r.start)
    else $error("disabled converter still requested");

  AST_FLAG_SET_WINS: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_done && clk_en) |=> conv_done_flag_r)
    else $error("completion flag not set");

  AST_TRIG_WHILE_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    (special_event_trig && !converter_enable_r && !go_r && clk_en && !(apb_wr && hit_c0))
    |=> !go_r && trig_timer_clear_r)
    else $error("trigger started a disabled converter");
endmodule // adcr_ctrl

// [testbench/adcr_core_model.sv]
// converter core stand-in: counts conversion clock ticks and answers
module adcr_core_model
  import adcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request side
  input wire adcr_core_req_s core_req,
  input wire logic tad_tick,
  input wire logic [ADCR_RES_W-1:0] sample_val,
  // answer side
  output adcr_core_rsp_s core_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_r; // conversion running
  logic done_r; // completion pulse
  logic [3:0] cnt_r; // converted top bits so far
  // one bit per conversion clock tick, ten ticks per result
  always_ff @(posedge core_clk) begin
    if (sys_rst || !core_req.enable) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      done_r <= 1'b0;
      if (core_req.start) begin
        busy_r <= 1'b1;
        cnt_r <= 4'h0;
      end else if (core_req.abort) begin
        busy_r <= 1'b0;
      end else if (busy_r && tad_tick) begin
        cnt_r <= cnt_r + 4'h1;
        // ends on the tenth tick; timing margins are the user's concern
        if (cnt_r == 4'h9) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
  // unconverted or stale bits carry the inverse, never a usable value
  always_comb begin
    for (int i = 0; i < ADCR_RES_W; i++) begin
      core_rsp.result[9-i] = ((busy_r || done_r) && (i < cnt_r))
        ? sample_val[9-i] : ~sample_val[9-i];
    end
    core_rsp.done = done_r;
    core_rsp.bits_done = cnt_r;
  end
endmodule // adcr_core_model

// [testbench/test_adc_control_and_result_regs.sv]
// register-level bench of the converter control block
module test_adc_control_and_result_regs
  import adcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0; // system clock
  logic sys_rst = 1'b1; // synchronous reset
  logic clk_en = 1'b1; // clock enable, dropped once to check the freeze
  logic psel = 1'b0; // apb master controls
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_r; // apb answers
  logic pready_r;
  logic pslverr_r;
  logic special_event_trig = 1'b0; // compare unit pulse
  logic trig_timer_clear_r;
  adcr_core_req_s core_req_r; // core request
  adcr_core_rsp_s core_rsp; // core answer
  logic rc_tick = 1'b0; // rc oscillator stand-in
  logic tad_tick_r;
  logic conv_done_flag_r;
  logic [9:0] sample_val = 10'h0; // value the core converts
  logic [2:0] rc_cnt = 3'h0; // rc period of seven cycles
  logic [15:0] cyc = 16'h0; // free cycle count
  logic [15:0] last_tick = 16'h0; // time of previous tick
  logic [7:0] tad_gap = 8'h0; // spacing of last two ticks
  int n_fail = 0;
  int n_checks = 0;
  always #50 core_clk = ~core_clk;
  adcr_ctrl adcr_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .special_event_trig(special_event_trig), .trig_timer_clear_r(trig_timer_clear_r),
    .core_req_r(core_req_r), .core_rsp(core_rsp), .rc_tick(rc_tick),
    .tad_tick_r(tad_tick_r), .conv_done_flag_r(conv_done_flag_r));
  adcr_core_model adcr_core_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .core_req(core_req_r), .tad_tick(tad_tick_r), .sample_val(sample_val), .core_rsp(core_rsp));
  // rc ticks and conversion clock spacing monitor
  always @(posedge core_clk) begin
    cyc <= cyc + 16'h1;
    rc_cnt <= (rc_cnt == 3'h6) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h6);
    if (tad_tick_r === 1'b1) begin
      tad_gap <= 8'(cyc - last_tick);
      last_tick <= cyc;
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready_r !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      $display("Error at %0t: bus answer missing", $time);
      wrap_up();
    end
    q = prdata_r;
    e = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk_val(q, exp);
  endtask
  // poll the start bit, then check flag and both result words
  task automatic wait_done(input logic j, input logic [9:0] v);
    logic [31:0] q;
    logic e;
    int k;
    k = 0;
    do begin
      apb(1'b0, ADCR_OFF_CTRL0, 32'h0, q, e);
      k++;
    end while (q[1] !== 1'b0 && k < 500);
    chk_bit(k < 500, 1'b1);
    if (k >= 500) wrap_up();
    chk_bit(conv_done_flag_r, 1'b1);
    rd(ADCR_OFF_STAT, 32'h1);
    rd(ADCR_OFF_RESH, j ? {6'h0, v[9:8]} : v[9:2]);
    rd(ADCR_OFF_RESL, j ? v[7:0] : {v[1:0], 6'h0});
    wr(ADCR_OFF_STAT, 32'h1);
    rd(ADCR_OFF_STAT, 32'h0);
  endtask
  task automatic trig_pulse();
    special_event_trig <= 1'b1;
    @(posedge core_clk);
    special_event_trig <= 1'b0;
    @(posedge core_clk);
    chk_bit(trig_timer_clear_r, 1'b1);
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    logic [9:0] v;
    logic [7:0] gap;
    int k;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(ADCR_OFF_CTRL0, 32'h0);
    rd(ADCR_OFF_CTRL1, 32'h0);
    wr(ADCR_OFF_CTRL0, 32'hFC);
    rd(ADCR_OFF_CTRL0, 32'h7C);
    wr(ADCR_OFF_CTRL1, 32'hFF);
    rd(ADCR_OFF_CTRL1, 32'hF3);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk_bit(e, 1'b1);
    chk_val(q, 32'h0);
    $display("test reserved bits done");
    // every channel code, converter on
    for (int c = 0; c < 32; c++) begin
      wr(ADCR_OFF_CTRL0, 32'(c * 4 + 1));
      @(posedge core_clk); // request word follows one edge after the write
      chk_val(32'(core_req_r.channel), 32'(c));
      chk_bit(core_req_r.connect, (c < 4) || (c > 28));
      chk_bit(core_req_r.enable, 1'b1);
    end
    for (int p = 0; p < 4; p++) begin
      wr(ADCR_OFF_CTRL1, 32'(p));
      @(posedge core_clk);
      chk_val(32'(core_req_r.pos_ref), 32'(p));
    end
    wr(ADCR_OFF_CTRL0, 32'h0);
    @(posedge core_clk);
    chk_bit(core_req_r.enable, 1'b0);
    $display("test selections done");
    // every clock code, both justifications
    for (int cs = 0; cs < 8; cs++) begin
      v = 10'(10'h1B3 + cs * 10'h57);
      sample_val <= v;
      wr(ADCR_OFF_CTRL1, 32'(cs[0] * 128 + cs * 16));
      wr(ADCR_OFF_CTRL0, 32'h01);
      wr(ADCR_OFF_CTRL0, 32'h03);
      wait_done(cs[0], v);
      case (cs)
        0: gap = 8'h02;
        1: gap = 8'h08;
        2: gap = 8'h20;
        4: gap = 8'h04;
        5: gap = 8'h10;
        6: gap = 8'h40;
        default: gap = 8'h07;
      endcase
      chk_val(32'(tad_gap), 32'(gap));
    end
    $display("test conversions done");
    v = 10'h2C6;
    sample_val <= v;
    wr(ADCR_OFF_CTRL1, 32'h80);
    wr(ADCR_OFF_CTRL0, 32'h01);
    trig_pulse();
    rd(ADCR_OFF_CTRL0, 32'h03);
    wait_done(1'b1, v);
    wr(ADCR_OFF_CTRL0, 32'h00);
    trig_pulse();
    rd(ADCR_OFF_CTRL0, 32'h00);
    // a frozen block must ignore the trigger
    wr(ADCR_OFF_CTRL0, 32'h01);
    clk_en <= 1'b0;
    special_event_trig <= 1'b1;
    @(posedge core_clk);
    special_event_trig <= 1'b0;
    @(posedge core_clk);
    chk_bit(trig_timer_clear_r, 1'b0);
    clk_en <= 1'b1;
    rd(ADCR_OFF_CTRL0, 32'h01);
    $display("test trigger done");
    // stop after three converted bits
    wr(ADCR_OFF_CTRL1, 32'hE0);
    wr(ADCR_OFF_CTRL0, 32'h01);
    wr(ADCR_OFF_CTRL0, 32'h03);
    k = 0;
    while (core_rsp.bits_done !== 4'h3 && k < 1000) begin
      @(posedge core_clk);
      k++;
    end
    chk_bit(k < 1000, 1'b1);
    wr(ADCR_OFF_CTRL0, 32'h01);
    @(posedge core_clk);
    chk_bit(core_req_r.abort, 1'b1);
    @(posedge core_clk);
    rd(ADCR_OFF_CTRL0, 32'h01);
    rd(ADCR_OFF_RESH, {6'h0, v[9:8]});
    rd(ADCR_OFF_RESL, {v[7], {7{v[7]}}});
    $display("test abort done");
    // results keep their contents over reset
    wr(ADCR_OFF_RESH, 32'h5A);
    wr(ADCR_OFF_CTRL0, 32'h7D);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(ADCR_OFF_RESH, 32'h5A);
    rd(ADCR_OFF_CTRL0, 32'h00);
    rd(ADCR_OFF_CTRL1, 32'h00);
    $display("test reset done");
    wrap_up();
  end
endmodule // test_adc_control_and_result_regs
